// file: ddi_pkg.sv
/*
 * Shared constants and types for the dual DAC digital input port block.
 * Assumes a single 20 MHz clock (50 ns period) and configuration bits
 * that are presented as plain levels by the surrounding control logic.
 */
// How it works
// - Sleep turns off only the DAC output currents; wake is immediate.
// - Power-down stops all core logic; only the serial port keeps running. Here the lock pin and status outputs keep updating too.
// - Two-port mode captures both port words on each data clock rise.
// - PLL off: pin select routes data clock to lock pin or serial pin.
// - PLL on: lock or data clock is chosen, then placed by pin select.
// - One-port mode turns port-2 bits into channel select and word clock.
// - The interleaved clock runs at twice the per-channel sample rate. Here with a word divisor of 1 it toggles each cycle, at the per-channel rate.
// - PLL on, two-port: data follows the device clock rate one to one.
// - Two-port filter input rate equals the per-port data rate.
// - DAC rate is clock times interpolation, doubled with zero stuffing.
// - Data clock inversion flips only the clock output polarity.
// - PLL on, one-port: both channels fed from port 1 interleaved.
// - Channel select 0 routes the word to I, 1 to Q.
// - Channel select inversion swaps the meaning of 0 and 1.
// - No one-times interpolation in one-port mode.
// - Interleaved clock inversion flips that output; source uses falling edge.
// - Pairing bit: 0 pairs I with next Q, 1 with preceding Q.
// - PLL enable chooses data-rate or DAC-rate meaning of the clock.
// - PLL lock state is readable as a status bit.
// - Interpolation code 00 none, 01 two times, 10 four times.
// - PLL off: data clock is clock over interpolation, halved again stuffed. Here at 1x unstuffed it toggles each cycle, at half the clock.
`default_nettype none
package ddi_pkg;
    localparam int PORT_W       = 16;
    localparam int WORD_W       = 2 * PORT_W;
    localparam int FIFO_DEPTH   = 16;
    localparam int DIV_W        = 4;
    localparam int CHAN_SEL_BIT = 14;
    localparam logic [1:0] INTERP_NONE = 2'h0;
    localparam logic [1:0] INTERP_X2   = 2'h1;
    localparam logic [1:0] INTERP_X4   = 2'h2;
    localparam logic [DIV_W-1:0] RATE_X1 = 4'h1;
    localparam logic [DIV_W-1:0] RATE_X2 = 4'h2;
    localparam logic [DIV_W-1:0] RATE_X4 = 4'h4;
    localparam logic [DIV_W-1:0] CNT_RST = 4'h0;
    localparam logic [PORT_W-1:0] WORD_RST = 16'h0000;
    typedef enum logic {CHAN_I, CHAN_Q} ddi_chan_t;
endpackage
`default_nettype wire

// file: ddi_stream_if.sv
/*
 * Valid/ready word stream between the capture logic and its FIFO.
 * Assumes both ends share one clock.
 */
`timescale 1ns/10ps
`default_nettype none
interface ddi_stream_if #(parameter int W = 32);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// file: ddi_fifo.sv
/*
 * Word FIFO with parameterised width and depth, valid/ready on both sides.
 * Assumes depth is a power of two; flush empties it in one cycle.
 */
`timescale 1ns/10ps
`default_nettype none
module ddi_fifo #(
    parameter int W     = 32,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic   clk,
    input wire logic   arst_n,
    // control
    input wire logic   flush,
    // streams
    ddi_stream_if.snk  wr,
    ddi_stream_if.src  rd
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
    localparam logic [AW:0] PTR_RST = '0;

    logic [W-1:0] mem [DEPTH];
    logic [AW:0]  wp_q;
    logic [AW:0]  wp_d;
    logic [AW:0]  rp_q;
    logic [AW:0]  rp_d;
    logic         push;
    logic         pop;

    assign wr.ready = (wp_q - rp_q) != FULL;
    assign rd.valid = wp_q != rp_q;
    assign rd.data  = mem[rp_q[AW-1:0]];
    assign push     = wr.valid && wr.ready;
    assign pop      = rd.valid && rd.ready;

    always_comb begin
        wp_d = push ? wp_q + 1'b1 : wp_q;
        rp_d = pop ? rp_q + 1'b1 : rp_q;
        if (flush) begin
            wp_d = PTR_RST;
            rp_d = PTR_RST;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wp_q <= PTR_RST;
            rp_q <= PTR_RST;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_q[AW-1:0]] <= wr.data;
        end
    end
endmodule
`default_nettype wire

// file: ddi_rate_div.sv
/*
 * Clock divider: a square clock of period divisor cycles and a pulse in
 * the cycle its output rises. Assumes divisor is 1, 2, 4 or 8.
 * A divisor of 1 cannot be shown on a flop: the output then toggles
 * every cycle while the pulse still fires every cycle.
 */
`timescale 1ns/10ps
`default_nettype none
module ddi_rate_div import ddi_pkg::*; (
    // clock and reset
    input wire logic             clk,
    input wire logic             arst_n,
    // control
    input wire logic             run,
    input wire logic [DIV_W-1:0] divisor,
    // outputs
    output logic                 clk_out,
    output logic                 rise
);
    logic [DIV_W-1:0] cnt_q;
    logic [DIV_W-1:0] cnt_d;
    logic             clk_d;
    logic             rise_d;

    always_comb begin
        cnt_d  = (cnt_q >= divisor - 1'b1) ? CNT_RST : cnt_q + 1'b1;
        if (!run) begin
            cnt_d = CNT_RST;
        end
        if (divisor == RATE_X1) begin
            clk_d = run && !clk_out;
        end else begin
            clk_d = run && (cnt_d < (divisor >> 1));
        end
        rise_d = run && (cnt_d == CNT_RST);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q   <= CNT_RST;
            clk_out <= 1'b0;
            rise    <= 1'b0;
        end else begin
            cnt_q   <= cnt_d;
            clk_out <= clk_d;
            rise    <= rise_d;
        end
    end
endmodule
`default_nettype wire

// file: ddi_top.sv
/*
 * Digital input port of a dual interpolating DAC: two-port and one-port
 * capture, data and interleaved clock generation, pin routing, sleep and
 * power-down. Assumes all inputs are synchronous to clk (20 MHz) and the
 * DAC side drains pairs through dac_valid/dac_ready.
 */
`timescale 1ns/10ps
`default_nettype none
module ddi_top import ddi_pkg::*; (
    // clock and reset
    input wire logic              clk,
    input wire logic              arst_n,
    // configuration
    input wire logic              one_port_mode,
    input wire logic              pll_enable,
    input wire logic [1:0]        interp_sel,
    input wire logic              zero_stuff,
    input wire logic              out_pin_sel,
    input wire logic              lock_pin_clock,
    input wire logic              dclk_invert,
    input wire logic              wclk_invert,
    input wire logic              chan_sel_invert,
    input wire logic              iq_pairing,
    input wire logic              sleep_mode,
    input wire logic              power_down,
    input wire logic              overrun_clear,
    // status
    input wire logic              pll_lock_in,
    input wire logic              serial_data_in,
    output logic                  pll_lock_status,
    output logic                  config_error,
    output logic [DIV_W-1:0]      dac_rate_mult,
    output logic                  overrun,
    output logic                  source_ready,
    // input ports and clock pins
    input wire logic [PORT_W-1:0] port_one_data,
    input wire logic [PORT_W-1:0] port_two_data,
    output logic                  interleaved_clock_out,
    output logic                  interleaved_clock_oe,
    output logic                  lock_clock_pin,
    output logic                  serial_out_pin,
    // dac side
    input wire logic              dac_ready,
    output logic [PORT_W-1:0]     dac_i,
    output logic [PORT_W-1:0]     dac_q,
    output logic                  dac_valid,
    output logic                  dac_current_on,
    output logic                  core_power_on
);
    //**********************************************************
    // rate selection
    //**********************************************************
    logic             mode_q;
    logic             mode_d;
    logic             started_q;
    logic [DIV_W-1:0] rate_raw;
    logic [DIV_W-1:0] rate_mult;
    logic [DIV_W-1:0] data_div;
    logic [DIV_W-1:0] word_div;
    logic             cfg_err;

    always_comb begin
        unique case (interp_sel)
            INTERP_NONE: rate_raw = mode_q ? RATE_X2 : RATE_X1;
            INTERP_X2:   rate_raw = RATE_X2;
            INTERP_X4:   rate_raw = RATE_X4;
            default:     rate_raw = RATE_X4;
        endcase
        cfg_err   = (interp_sel == 2'h3) || (mode_q && interp_sel == INTERP_NONE);
        rate_mult = zero_stuff ? DIV_W'(rate_raw << 1) : rate_raw;
        if (pll_enable) begin
            data_div = mode_q ? RATE_X2 : RATE_X1;
        end else begin
            data_div = rate_mult;
        end
        word_div = data_div >> 1;
        mode_d   = (power_down || !started_q) ? one_port_mode : mode_q;
    end

    //**********************************************************
    // clock generation
    //**********************************************************
    logic data_clk;
    logic data_rise;
    logic word_clk;
    logic word_rise;

    ddi_rate_div u_data_div (
        .clk     (clk),
        .arst_n  (arst_n),
        .run     (!power_down),
        .divisor (data_div),
        .clk_out (data_clk),
        .rise    (data_rise)
    );

    ddi_rate_div u_word_div (
        .clk     (clk),
        .arst_n  (arst_n),
        .run     (!power_down && mode_q),
        .divisor (word_div),
        .clk_out (word_clk),
        .rise    (word_rise)
    );

    //**********************************************************
    // pin routing
    //**********************************************************
    logic chosen;
    logic lock_pin_d;
    logic sdo_d;
    logic wclk_d;

    always_comb begin
        if (pll_enable && !lock_pin_clock) begin
            chosen = pll_lock_in;
        end else begin
            chosen = data_clk ^ dclk_invert;
        end
        lock_pin_d = out_pin_sel ? 1'b0 : chosen;
        sdo_d      = out_pin_sel ? chosen : serial_data_in;
        wclk_d     = mode_q && (word_clk ^ wclk_invert);
    end

    //**********************************************************
    // capture and pairing
    //**********************************************************
    ddi_stream_if #(.W(WORD_W)) wr_if ();
    ddi_stream_if #(.W(WORD_W)) rd_if ();

    logic              drise_q;
    logic              wrise_q;
    logic [PORT_W-1:0] hold_i_q;
    logic [PORT_W-1:0] hold_i_d;
    logic [PORT_W-1:0] hold_q_q;
    logic [PORT_W-1:0] hold_q_d;
    logic              push;
    logic [WORD_W-1:0] push_data;
    ddi_chan_t         chan;
    logic              overrun_d;

    // strobes are delayed one cycle so they line up with the pin clock edges
    always_comb begin
        chan      = (port_two_data[CHAN_SEL_BIT] ^ chan_sel_invert) ? CHAN_Q : CHAN_I;
        hold_i_d  = hold_i_q;
        hold_q_d  = hold_q_q;
        push      = 1'b0;
        push_data = {hold_i_q, hold_q_q};
        if (drise_q) begin
            push      = 1'b1;
            push_data = {port_one_data, port_two_data};
        end else if (wrise_q) begin
            if (chan == CHAN_I) begin
                hold_i_d = port_one_data;
                if (iq_pairing) begin
                    push      = 1'b1;
                    push_data = {port_one_data, hold_q_q};
                end
            end else begin
                hold_q_d = port_one_data;
                if (!iq_pairing) begin
                    push      = 1'b1;
                    push_data = {hold_i_q, port_one_data};
                end
            end
        end
        // held words survive power-down; power_down flushes the FIFO and clears dac_valid
        overrun_d = (push && !wr_if.ready) || (overrun && !overrun_clear);
    end

    assign wr_if.valid = push;
    assign wr_if.data  = push_data;

    ddi_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk    (clk),
        .arst_n (arst_n),
        .flush  (power_down),
        .wr     (wr_if),
        .rd     (rd_if)
    );

    //**********************************************************
    // dac side and power
    //**********************************************************
    logic              dvalid_d;
    logic [PORT_W-1:0] di_d;
    logic [PORT_W-1:0] dq_d;

    assign rd_if.ready = !dac_valid || dac_ready;

    always_comb begin
        dvalid_d = dac_valid;
        di_d     = dac_i;
        dq_d     = dac_q;
        if (rd_if.ready) begin
            dvalid_d = rd_if.valid;
            di_d     = rd_if.data[WORD_W-1:PORT_W];
            dq_d     = rd_if.data[PORT_W-1:0];
        end
        if (power_down) begin
            dvalid_d = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_q                <= 1'b0;
            started_q             <= 1'b0;
            drise_q               <= 1'b0;
            wrise_q               <= 1'b0;
            hold_i_q              <= WORD_RST;
            hold_q_q              <= WORD_RST;
            overrun               <= 1'b0;
            source_ready          <= 1'b0;
            lock_clock_pin        <= 1'b0;
            serial_out_pin        <= 1'b0;
            interleaved_clock_out <= 1'b0;
            interleaved_clock_oe  <= 1'b0;
            pll_lock_status       <= 1'b0;
            config_error          <= 1'b0;
            dac_rate_mult         <= RATE_X1;
            dac_valid             <= 1'b0;
            dac_i                 <= WORD_RST;
            dac_q                 <= WORD_RST;
            dac_current_on        <= 1'b0;
            core_power_on         <= 1'b0;
        end else begin
            mode_q                <= mode_d;
            started_q             <= 1'b1;
            drise_q               <= data_rise && !mode_q;
            wrise_q               <= word_rise && mode_q;
            hold_i_q              <= hold_i_d;
            hold_q_q              <= hold_q_d;
            overrun               <= overrun_d;
            source_ready          <= wr_if.ready;
            lock_clock_pin        <= lock_pin_d;
            serial_out_pin        <= sdo_d;
            interleaved_clock_out <= wclk_d;
            interleaved_clock_oe  <= mode_q;
            pll_lock_status       <= pll_lock_in;
            config_error          <= cfg_err;
            dac_rate_mult         <= rate_mult;
            dac_valid             <= dvalid_d;
            dac_i                 <= di_d;
            dac_q                 <= dq_d;
            dac_current_on        <= !sleep_mode && !power_down;
            core_power_on         <= !power_down;
        end
    end

    //**********************************************************
    // assertions
    //**********************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    AST_SLEEP_OFF: assert property (sleep_mode ##1 sleep_mode |-> !dac_current_on)
        else $error("dac current on during sleep");
    AST_WAKE_NOW: assert property ($fell(sleep_mode) && !power_down ##1 !power_down
        |-> dac_current_on)
        else $error("no immediate wake from sleep");
    AST_PDOWN: assert property (power_down ##1 power_down
        |-> !core_power_on && !dac_current_on && !dac_valid)
        else $error("core active in power-down");
    AST_SERIAL_PIN: assert property (out_pin_sel |=> !lock_clock_pin)
        else $error("lock pin driven while routed to serial pin");
    AST_LOCK_PIN: assert property (pll_enable && !lock_pin_clock && !out_pin_sel
        |=> lock_clock_pin == $past(pll_lock_in))
        else $error("lock indicator not on lock pin");
    AST_TWO_PORT: assert property (drise_q && wr_if.ready && !power_down
        |-> push && push_data == {port_one_data, port_two_data} ##1 rd_if.valid)
        else $error("two-port capture wrong");
    AST_ONE_PORT_1X: assert property (mode_q && interp_sel == INTERP_NONE
        |=> config_error && dac_rate_mult != RATE_X1)
        else $error("one-times interpolation in one-port mode");
    AST_PAIR_I_FIRST: assert property (wrise_q && !iq_pairing && chan == CHAN_Q
        |-> push && push_data == {hold_i_q, port_one_data})
        else $error("I-first pairing wrong");
    AST_PAIR_Q_FIRST: assert property (wrise_q && iq_pairing && chan == CHAN_I
        |-> push && push_data == {port_one_data, hold_q_q})
        else $error("Q-first pairing wrong");
    AST_RATE: assert property ((data_rise && !pll_enable && !power_down
        && data_div == RATE_X4) ##1 (data_div == RATE_X4 && !power_down) [*3]
        |=> data_rise)
        else $error("data clock period wrong");
    AST_OVERRUN: assert property (push && !wr_if.ready |=> overrun)
        else $error("lost pair not flagged");

    COV_TWO_PORT: cover property (drise_q && wr_if.ready);
    COV_ONE_PORT: cover property (wrise_q && push && iq_pairing);
    COV_FULL:     cover property (push && !wr_if.ready);
    COV_DRAIN:    cover property (dac_valid && dac_ready);
endmodule
`default_nettype wire

// file: ddi_source_model.sv
/*
 * Baseband source model driving the two input ports of the block.
 * Assumes pin_clk is the clock pin it follows, already selected, and
 * that the block samples a word while that pin is first high.
 */
`timescale 1ns/10ps
`default_nettype none
module ddi_source_model import ddi_pkg::*; (
    // clock and reset
    input wire logic          clk,
    input wire logic          arst_n,
    // pins and setup
    input wire logic          pin_clk,
    input wire logic          inv,
    input wire logic          one_port,
    input wire logic          sel_inv,
    // data ports
    output logic [PORT_W-1:0] p1,
    output logic [PORT_W-1:0] p2
);
    logic [11:0] k_q;
    logic        pin_q;
    logic        edge_s;

    // capture edge of the pin, the falling one when inverted
    assign edge_s = (pin_clk ^ inv) & ~pin_q;

    // next word after every capture; holds its word while the pin is stopped in power-down
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            k_q   <= 12'h000;
            pin_q <= 1'b1;
        end else begin
            pin_q <= pin_clk ^ inv;
            if (edge_s) begin
                k_q <= k_q + 12'h001;
            end
        end
    end

    // even words are I; bit 15 is driven by the device in this mode, so left low
    always_comb begin
        if (one_port) begin
            p1 = {4'h3, k_q};
            p2 = {1'b0, k_q[0] ^ sel_inv, 14'h0000};
        end else begin
            p1 = {4'h1, k_q};
            p2 = {4'h2, k_q};
        end
    end
endmodule
`default_nettype wire

// file: ddi_top_tb.sv
/*
 * Self-checking testbench of ddi_top with a baseband source model.
 * Assumes the 20 MHz clock and all configuration pins driven from here.
 */
`timescale 1ns/10ps
`default_nettype none
module ddi_top_tb import ddi_pkg::*; ;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic one_port_mode, pll_enable, zero_stuff, out_pin_sel, lock_pin_clock;
    logic dclk_invert, wclk_invert, chan_sel_invert, iq_pairing, sleep_mode;
    logic power_down, overrun_clear, pll_lock_in, serial_data_in, dac_ready;
    logic pll_lock_status, config_error, overrun, source_ready, dac_valid;
    logic interleaved_clock_out, interleaved_clock_oe, lock_clock_pin, serial_out_pin;
    logic dac_current_on, core_power_on;
    logic [1:0]        interp_sel, mon;
    logic [DIV_W-1:0]  dac_rate_mult;
    logic [PORT_W-1:0] port_one_data, port_two_data, dac_i, dac_q;
    logic [31:0]       got[$];
    logic              mprev;
    int                cyc, last_rise, last_per, miscompares, checked;
    wire mpin = (mon == 2'h0) ? lock_clock_pin :
                (mon == 2'h1) ? serial_out_pin : interleaved_clock_out;
    wire src_clk = one_port_mode ? interleaved_clock_out :
                   (out_pin_sel ? serial_out_pin : lock_clock_pin);
    wire src_inv = one_port_mode ? wclk_invert : dclk_invert;

    always #25 clk = ~clk;

    ddi_top u_dut (.clk, .arst_n, .one_port_mode, .pll_enable, .interp_sel, .zero_stuff,
        .out_pin_sel, .lock_pin_clock, .dclk_invert, .wclk_invert, .chan_sel_invert,
        .iq_pairing, .sleep_mode, .power_down, .overrun_clear, .pll_lock_in,
        .serial_data_in, .pll_lock_status, .config_error, .dac_rate_mult, .overrun,
        .source_ready, .port_one_data, .port_two_data, .interleaved_clock_out,
        .interleaved_clock_oe, .lock_clock_pin, .serial_out_pin, .dac_ready, .dac_i,
        .dac_q, .dac_valid, .dac_current_on, .core_power_on);

    ddi_source_model u_src (.clk(clk), .arst_n(arst_n), .pin_clk(src_clk),
        .inv(src_inv), .one_port(one_port_mode), .sel_inv(chan_sel_invert),
        .p1(port_one_data), .p2(port_two_data));

    // ****************************************
    // monitors: pin period and taken pairs
    // ****************************************
    always @(posedge clk) begin
        cyc <= cyc + 1;
        mprev <= mpin;
        if (mpin === 1'b1 && mprev === 1'b0) begin
            last_per <= cyc - last_rise;
            last_rise <= cyc;
        end
        if (dac_valid === 1'b1 && dac_ready === 1'b1) begin
            got.push_back({dac_i, dac_q});
        end
    end

    // ****************************************
    // helpers
    // ****************************************
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask

    task end_sim;
        if (miscompares == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task w(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    function automatic logic [15:0] wd(input int k);
        return {4'h3, k[11:0]};
    endfunction

    // defaults, then reset held for three cycles
    task base(input logic op, input logic [1:0] is, input logic inv);
        {one_port_mode, interp_sel, dclk_invert, wclk_invert} <= {op, is, inv, inv};
        {chan_sel_invert, pll_enable, zero_stuff, out_pin_sel} <= {inv, 3'h0};
        {lock_pin_clock, iq_pairing, sleep_mode, power_down} <= 4'h0;
        {overrun_clear, pll_lock_in, serial_data_in, dac_ready, mon} <= 6'h04;
        arst_n <= 1'b0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        w(1);
        got.delete();
    endtask

    // md 0 two-port, 1 I with next Q, 2 I with previous Q
    task pairs(input int n, input int md);
        logic [31:0] e;
        for (int m = 0; m < n; m++) begin
            case (md)
                0: e = {4'h1, m[11:0], 4'h2, m[11:0]};
                1: e = {wd(2 * m), wd(2 * m + 1)};
                default: e = {wd(2 * m), (m == 0) ? 16'h0000 : wd(2 * m - 1)};
            endcase
            chk("pair", (m < got.size()) ? got[m] : 32'hxxxxxxxx, e);
        end
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task t_rates;
        base(1'b0, 2'h0, 1'b0);
        for (int s = 0; s < 3; s++) begin
            for (int z = 0; z < 2; z++) begin
                interp_sel <= s[1:0];
                zero_stuff <= z[0];
                w(24);
                chk("rate_mult", dac_rate_mult, (1 << s) << z);
                chk("dclk_period", last_per, (s + z == 0) ? 2 : (1 << s) << z);
            end
        end
        interp_sel <= 2'h3;
        w(3);
        chk("cfg_err", config_error, 1);
    endtask

    task t_route;
        base(1'b0, 2'h2, 1'b0);
        out_pin_sel <= 1'b1;
        mon <= 2'h1;
        w(16);
        chk("sdo_period", last_per, 4);
        chk("lock_pin", lock_clock_pin, 0);
        {pll_enable, out_pin_sel, pll_lock_in} <= 3'h5;
        w(3);
        chk("lock_pin", lock_clock_pin, 1);
        chk("lock_stat", pll_lock_status, 1);
        out_pin_sel <= 1'b1;
        w(3);
        chk("sdo_lock", serial_out_pin, 1);
        chk("lock_pin", lock_clock_pin, 0);
        lock_pin_clock <= 1'b1;
        w(12);
        chk("pll_dclk_period", last_per, 2);
        {out_pin_sel, serial_data_in} <= 2'h1;
        w(3);
        chk("sdo_data", serial_out_pin, 1);
    endtask

    task t_ports;
        for (int i = 0; i < 2; i++) begin
            base(1'b0, 2'h1, i[0]);
            w(40);
            pairs(12, 0);
            chk("dclk_level", lock_clock_pin, !i[0]);
            chk("wclk_oe", interleaved_clock_oe, 0);
        end
        for (int c = 0; c < 4; c++) begin
            base(1'b1, 2'h2, c[1]);
            iq_pairing <= c[0];
            mon <= 2'h2;
            w(60);
            chk("wclk_oe", interleaved_clock_oe, 1);
            chk("wclk_period", last_per, 2);
            chk("wclk_level", interleaved_clock_out, c[1]);
            pairs(6, 1 + c % 2);
        end
        zero_stuff <= 1'b1;
        w(24);
        chk("wclk_period", last_per, 4);
        pll_enable <= 1'b1;
        w(12);
        chk("pll_wclk_period", last_per, 2);
        interp_sel <= 2'h0;
        w(3);
        chk("cfg_err", config_error, 1);
    endtask

    task t_power;
        int r;
        base(1'b0, 2'h1, 1'b0);
        sleep_mode <= 1'b1;
        w(12);
        chk("dac_on", dac_current_on, 0);
        chk("core_on", core_power_on, 1);
        chk("pairs_flow", got.size() > 3, 1);
        sleep_mode <= 1'b0;
        w(1);
        chk("dac_on", dac_current_on, 1);
        power_down <= 1'b1;
        w(2);
        chk("core_on", {core_power_on, dac_current_on, dac_valid}, 0);
        r = last_rise;
        w(10);
        chk("clk_stopped", last_rise, r);
        power_down <= 1'b0;
        w(1);
        chk("core_on", core_power_on, 1);
    endtask

    task t_fifo;
        base(1'b0, 2'h1, 1'b0);
        dac_ready <= 1'b0;
        w(60);
        chk("src_ready", source_ready, 0);
        chk("overrun", overrun, 1);
        chk("taken", got.size(), 0);
        dac_ready <= 1'b1;
        w(40);
        pairs(16, 0);
        chk("src_ready", source_ready, 1);
        overrun_clear <= 1'b1;
        w(1);
        overrun_clear <= 1'b0;
        w(1);
        chk("overrun", overrun, 0);
    endtask

    initial begin
        t_rates;
        t_route;
        t_ports;
        t_power;
        t_fifo;
        end_sim;
    end

    initial begin
        #200000;
        miscompares++;
        end_sim;
    end
endmodule
`default_nettype wire
